// [bench/serial_irq_unit_tb.sv]
// self-checking bench of one serial channel with its interrupt requests
`timescale 1ns/1ps
module serial_irq_unit_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic ext_clk = 1'b1, cts_n = 1'b1, peer_ld = 1'b0, es = 1'b0;
    logic rd_dp = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] peer_byte = 8'h00, d, p, got;
    logic [31:0] hrdata;
    logic hreadyout, hresp, ck_o, ck_oe, sout, sin, sck, rts_n;
    logic rxq, txq, clq, irq, done;
    logic [31:0] expq[$], mskq[$];
    int fails = 0, n_compared = 0;

    always #5 hclk = ~hclk;
    // wire level: the device drives the clock only while its enable is up
    assign sck = ck_oe ? ck_o : ext_clk;

    serial_irq_unit #(.CHANNEL(2), .HALF_CYCLES(4)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .serial_clock_pin_i(sck), .serial_clock_pin_o(ck_o),
        .serial_clock_pin_oe(ck_oe), .serial_out_pin(sout),
        .serial_in_pin(sin), .cts_n(cts_n), .rts_n(rts_n),
        .rx_vector_req(rxq), .tx_vector_req(txq), .coll_vector_req(clq),
        .irq(irq));

    serial_peer u_peer (.sck(sck), .edge_sel(es), .txd(sout), .ld(peer_ld),
        .ld_byte(peer_byte), .sdo(sin), .got(got), .done(done));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bit1(input logic v, input logic e);
        chk({31'h0, v}, {31'h0, e});
    endtask

    // one single word transfer; ends 1 ns after the data phase edge
    task automatic bus(input logic w, input logic [11:0] i,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {18'h0, i, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rd_dp <= ~w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] i, input logic [31:0] wd);
        bus(1'b1, i, wd);
    endtask

    task automatic rd(input logic [11:0] i, input logic [31:0] e,
                      input logic [31:0] m);
        expq.push_back(e);
        mskq.push_back(m);
        bus(1'b0, i, 32'h0);
    endtask

    task automatic settle();
        repeat (6) @(posedge hclk);
        #1;
    endtask

    // arm the peer, then hand the device its transmit word
    task automatic start(input logic [7:0] td, input logic [7:0] pd);
        @(posedge hclk);
        // byte before strobe, so the peer never loads a stale byte
        peer_byte <= pd;
        peer_ld <= 1'b1;
        @(posedge hclk);
        peer_ld <= 1'b0;
        wr(serial_irq_pkg::IDX_TXB, {24'h0, td});
    endtask

    task automatic finish();
        for (int i = 0; i < 600 && done !== 1'b1; i++) @(posedge hclk);
        settle();
        bit1(done, 1'b1);
    endtask

    task automatic frame(input logic [7:0] td, input logic [7:0] pd);
        start(td, pd);
        finish();
    endtask

    // the link clock runs only inside a frame
    task automatic ext_frame();
        for (int i = 0; i < 16; i++) #62.5 ext_clk = ~ext_clk;
    endtask

    // the watcher compares each read with the oldest expectation
    always @(posedge hclk) begin
        if (rd_dp && hreadyout && expq.size() > 0) begin
            chk(hrdata & mskq.pop_front(), expq.pop_front());
        end
    end

    task automatic summarize();
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a hang costs a mismatch and ends the run the normal way
    initial begin
        #300000;
        fails++;
        summarize();
    end

    initial begin
        void'($urandom(32'h78ea));
        d = 8'($urandom());
        p = 8'($urandom());
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, an unmapped index, a select round trip
        rd(serial_irq_pkg::IDX_SEL_A, 32'h0, '1);
        rd(serial_irq_pkg::IDX_SEL_B, 32'h0, '1);
        rd(12'h50, 32'h0, '1);
        rd(12'h3ff, 32'h0, '1);
        wr(serial_irq_pkg::IDX_SEL_B, {24'h0, d});
        rd(serial_irq_pkg::IDX_SEL_B, {24'h0, d}, '1);
        // completion select with error output right after reset
        wr(serial_irq_pkg::IDX_XFER, 32'h18);
        settle();
        bit1(txq, 1'b1);
        wr(12'h4f, 32'h0);
        bit1(txq, 1'b0);
        // internal clock with flow control asked for: it must stay off
        wr(serial_irq_pkg::IDX_MODE, 32'h18);
        wr(serial_irq_pkg::IDX_XFER, 32'h3);
        wr(serial_irq_pkg::IDX_MASK, 32'h0);
        frame(d, p);
        chk({24'h0, got}, {24'h0, d});
        bit1(rxq, 1'b1);
        bit1(rts_n, 1'b1);
        bit1(irq, 1'b0);
        rd(serial_irq_pkg::IDX_RXB, {22'h0, 2'b10, p}, 32'h3ff);
        bit1(rxq, 1'b1);
        wr(serial_irq_pkg::IDX_MASK, 32'h1);
        bit1(irq, 1'b1);
        wr(serial_irq_pkg::IDX_STAT, 32'h1);
        bit1(irq, 1'b0);
        // second word lands before the first is read
        wr(12'h50, 32'h0);
        frame(~d, ~p);
        wr(12'h50, 32'h0);
        frame(d, p);
        bit1(rxq, 1'b0);
        rd(serial_irq_pkg::IDX_RXB, 32'h300, 32'h300);
        // two-wire mode: a mode change and an overrun both raise requests
        wr(serial_irq_pkg::IDX_MODE, 32'ha);
        settle();
        bit1(rxq, 1'b1);
        wr(12'h50, 32'h0);
        wr(12'h4f, 32'h0);
        frame(d, p);
        wr(12'h50, 32'h0);
        frame(~d, ~p);
        bit1(rxq, 1'b1);
        rd(serial_irq_pkg::IDX_RXB, 32'h300, 32'h300);
        // start condition: data low, half a clock, then the request
        wr(12'h4a, 32'h0);
        wr(serial_irq_pkg::IDX_XFER, 32'h3);
        settle();
        wr(serial_irq_pkg::IDX_XFER, 32'h63);
        for (int i = 0; i < 100 && clq !== 1'b1; i++) @(posedge hclk);
        settle();
        bit1(clq, 1'b1);
        // external clock on the other edge, with flow control
        ext_clk <= 1'b0;
        es = 1'b1;
        wr(serial_irq_pkg::IDX_XFER, 32'h7);
        wr(serial_irq_pkg::IDX_MODE, 32'h30);
        wr(12'h50, 32'h0);
        settle();
        bit1(rts_n, 1'b0);
        start(~d, ~p);
        settle();
        bit1(rts_n, 1'b0);
        @(posedge hclk);
        cts_n <= 1'b0;
        for (int i = 0; i < 100 && rts_n !== 1'b1; i++) @(posedge hclk);
        #1;
        bit1(rts_n, 1'b1);
        ext_frame();
        finish();
        chk({24'h0, got}, {24'h0, ~d});
        rd(serial_irq_pkg::IDX_RXB, {22'h0, 2'b10, ~p}, 32'h3ff);
        bit1(rts_n, 1'b0);
        summarize();
    end
endmodule

// [bench/serial_peer.sv]
// behavioural serial peer: shifts one byte out and captures one byte in
`timescale 1ns/1ps
module serial_peer (
    input wire logic sck, // shift clock level on the wire
    input wire logic edge_sel, // clock level reached by the lead edge
    input wire logic txd, // device serial output
    input wire logic ld, // rising edge loads a new byte
    input wire logic [7:0] ld_byte, // byte to send
    output logic sdo, // data towards the device
    output logic [7:0] got, // byte captured from the device
    output logic done // eight bits exchanged
);
    logic [7:0] sh = 8'h00;
    int n = 8;

    initial begin
        sdo = 1'b1;
        got = 8'h00;
    end
    assign done = (n == 8);

    // a load arms the peer for the next frame
    always @(posedge ld) begin
        sh = ld_byte;
        n = 0;
    end

    // lead edge puts a bit out, trail edge samples the device, lsb first
    always @(sck) begin
        if (n < 8 && sck === edge_sel) begin
            sdo <= sh[n];
        end else if (n < 8) begin
            got[n] = txd;
            n = n + 1;
        end
    end

    // the line toggles after a frame so a stale bit can never pass as data;
    // late enough that the synchronised last sample of the device is taken
    always @(posedge done) begin
        if ($time > 0) begin
            sdo <= #40 ~sdo;
        end
    end
endmodule

// [logic/serial_irq_unit.sv]
// one serial channel: sync shifter, flow control, interrupt requests
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module serial_irq_unit #(
    parameter int CHANNEL = 2, // channel number: 0, 1, 2, 5, 6 or 7
    parameter int HALF_CYCLES = 4 // internal shift clock half period
) (
    input logic hclk, // bus clock
    input logic hresetn, // async reset, active low
    input logic hsel, // slave select
    input logic [31:0] haddr, // byte address
    input logic [1:0] htrans, // transfer type
    input logic hwrite, // write when high
    input logic [2:0] hsize, // word only
    input logic [31:0] hwdata, // write data
    input logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    input logic serial_clock_pin_i, // shift clock pin level
    output logic serial_clock_pin_o, // shift clock drive
    output logic serial_clock_pin_oe, // high while clock driven
    output logic serial_out_pin, // serial data out
    input logic serial_in_pin, // serial data in
    input logic cts_n, // clear-to-send, low active
    output logic rts_n, // request-to-send, low active
    output logic rx_vector_req, // receive request flag
    output logic tx_vector_req, // transmit request flag
    output logic coll_vector_req, // collision/condition request flag
    output logic irq // masked sticky status
);
    localparam logic [11:0] IDX_RXC = serial_irq_pkg::ctl_idx(CHANNEL, 0);
    localparam logic [11:0] IDX_TXC = serial_irq_pkg::ctl_idx(CHANNEL, 1);
    localparam logic [11:0] IDX_CLC = serial_irq_pkg::ctl_idx(CHANNEL, 2);
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
    localparam int MW = $bits(serial_irq_pkg::mode_type);
    localparam int XW = $bits(serial_irq_pkg::xfer_type);
    localparam int CW = $bits(serial_irq_pkg::irqctl_type);
    localparam int EW = $bits(serial_irq_pkg::evt_type);

    if (!serial_irq_pkg::channel_ok(CHANNEL) || HALF_CYCLES < 1 ||
        HALF_CYCLES > 256) begin : g_bad_param
        $error("unsupported channel or half period");
    end

    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] din_s;
        logic [1:0] cts_s;
        logic clk_prev;
        serial_irq_pkg::mode_type mode;
        serial_irq_pkg::xfer_type xfer;
        logic [7:0] txbuf;
        logic tx_full;
        logic [7:0] rxbuf;
        logic rx_full;
        logic overrun;
        logic [7:0] tsh;
        logic [7:0] rsh;
        logic rx_act;
        logic [3:0] bitcnt;
        logic [7:0] div;
        logic clk_out;
        logic dout;
        serial_irq_pkg::state_type state;
        serial_irq_pkg::irqctl_type rxc;
        serial_irq_pkg::irqctl_type txc;
        serial_irq_pkg::irqctl_type clc;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        serial_irq_pkg::evt_type stat;
        serial_irq_pkg::evt_type mask;
        logic tx_arm_prev;
        logic rts_n;
        logic dph_wr;
        logic [11:0] dph_idx;
        logic [31:0] rdata;
    } unit_state_type;

    unit_state_type q;
    unit_state_type d;
    serial_irq_pkg::evt_type ev;
    logic acc;
    logic [11:0] idx;
    logic clk_now;
    logic idle_lvl;
    logic lead;
    logic trail;
    logic tick;
    logic cts_ok;
    logic start_ok;
    logic done;
    logic full_after_rd;
    logic two_wire;
    logic mode_chg;
    logic wr_rxc;
    logic wr_clc;
    logic coll_route;
    logic tx_route;
    logic cond_tgt;
    logic [31:0] rd;

    // next-state logic; order matters: read clears, shifter, writes, sets
    always_comb begin
        d = q;
        ev = '0;
        rd = '0;
        mode_chg = 1'b0;
        tick = 1'b0;
        done = 1'b0;
        d.clk_s = {q.clk_s[0], serial_clock_pin_i};
        d.din_s = {q.din_s[0], serial_in_pin};
        d.cts_s = {q.cts_s[0], cts_n};
        acc = hsel && hready && htrans[1];
        idx = haddr[serial_irq_pkg::ADDR_LSB +: serial_irq_pkg::IDX_W];
        wr_rxc = q.dph_wr && q.dph_idx == IDX_RXC;
        wr_clc = q.dph_wr && q.dph_idx == IDX_CLC;
        two_wire = q.mode.smd == serial_irq_pkg::MODE_TWO_WIRE;
        coll_route = serial_irq_pkg::route_ok(CHANNEL, 1'b0, q.sel_a,
                                              q.sel_b);
        tx_route = serial_irq_pkg::route_ok(CHANNEL, 1'b1, q.sel_a,
                                            q.sel_b);

        // clock edges, either from own divider or the synchronised pin
        clk_now = q.mode.int_clk ? q.clk_out : q.clk_s[1];
        d.clk_prev = clk_now;
        idle_lvl = ~q.xfer.edge_sel;
        lead = q.clk_prev == idle_lvl && clk_now != idle_lvl;
        trail = q.clk_prev != idle_lvl && clk_now == idle_lvl;
        cts_ok = !q.mode.cts_en || !q.cts_s[1];
        start_ok = q.xfer.tx_en && q.tx_full && cts_ok &&
                   (q.mode.int_clk || q.clk_s[1] == idle_lvl);
        cond_tgt = !(q.xfer.sta_req || q.xfer.rst_req);

        // bus read: data sampled in the address phase, flags cleared
        if (acc && !hwrite) begin
            unique case (idx)
                IDX_RXC: rd = 32'(q.rxc);
                IDX_TXC: rd = 32'(q.txc);
                IDX_CLC: rd = 32'(q.clc);
                serial_irq_pkg::IDX_SEL_A: rd = 32'(q.sel_a);
                serial_irq_pkg::IDX_SEL_B: rd = 32'(q.sel_b);
                serial_irq_pkg::IDX_MODE: rd = 32'(q.mode);
                serial_irq_pkg::IDX_XFER: rd = 32'(q.xfer);
                serial_irq_pkg::IDX_TXB: rd = 32'(q.txbuf);
                serial_irq_pkg::IDX_RXB: begin
                    rd = 32'({!q.tx_full, q.rx_full, q.overrun, q.rxbuf});
                    d.rx_full = 1'b0;
                    d.overrun = 1'b0;
                end
                serial_irq_pkg::IDX_STAT: rd = 32'(q.stat);
                serial_irq_pkg::IDX_MASK: rd = 32'(q.mask);
                default: rd = '0;
            endcase
        end
        d.rdata = rd;
        d.dph_wr = acc && hwrite;
        d.dph_idx = idx;
        full_after_rd = d.rx_full;

        // divider runs only while a frame or a condition is under way
        if (q.state != serial_irq_pkg::ST_IDLE) begin
            d.div = q.div + 8'h1;
            if (q.div == HALF_LAST) begin
                d.div = '0;
                tick = 1'b1;
            end
        end

        // shifter; the clock exists only while the transmitter runs
        unique case (q.state)
            serial_irq_pkg::ST_IDLE: begin
                d.div = '0;
                d.bitcnt = '0;
                d.clk_out = idle_lvl;
                d.dout = 1'b1;
                if (q.xfer.cond_sel &&
                    (q.xfer.sta_req || q.xfer.rst_req || q.xfer.stp_req)) begin
                    d.state = serial_irq_pkg::ST_COND;
                    d.dout = !cond_tgt;
                    d.clk_out = 1'b1;
                end else if (start_ok) begin
                    d.state = serial_irq_pkg::ST_SHIFT;
                    d.tsh = q.txbuf;
                    d.tx_full = 1'b0;
                    d.rx_act = q.xfer.rx_en;
                    ev.tx = !q.xfer.txirq_cmp;
                end
            end
            serial_irq_pkg::ST_SHIFT: begin
                if (q.mode.int_clk && tick) begin
                    d.clk_out = !q.clk_out;
                end
                if (lead) begin
                    d.dout = q.tsh[0];
                end
                if (trail) begin
                    d.rsh = {q.din_s[1], q.rsh[7:1]};
                    d.tsh = {1'b1, q.tsh[7:1]};
                    d.bitcnt = q.bitcnt + 4'h1;
                    ev.cond = two_wire && q.dout && !q.din_s[1];
                    done = q.bitcnt == serial_irq_pkg::FRAME_LAST;
                end
                if (done) begin
                    d.state = serial_irq_pkg::ST_IDLE;
                    ev.tx = q.xfer.txirq_cmp;
                    if (q.rx_act) begin
                        d.rxbuf = {q.din_s[1], q.rsh[7:1]};
                        d.rx_full = 1'b1;
                        ev.ovr = full_after_rd;
                        ev.rx = !full_after_rd;
                        // keep a same-cycle read clear, add the new overrun
                        d.overrun = d.overrun | full_after_rd;
                    end
                end
            end
            serial_irq_pkg::ST_COND: begin
                d.clk_out = 1'b1;
                if (tick) begin
                    d.bitcnt = q.bitcnt + 4'h1;
                    d.dout = cond_tgt;
                    if (q.bitcnt != '0) begin
                        d.state = serial_irq_pkg::ST_IDLE;
                        d.xfer.sta_req = 1'b0;
                        d.xfer.rst_req = 1'b0;
                        d.xfer.stp_req = 1'b0;
                        ev.cond = 1'b1;
                    end
                end
            end
            default: d.state = serial_irq_pkg::ST_IDLE;
        endcase

        // bus write, data phase; request flags only cleared by a 0 write
        if (q.dph_wr) begin
            unique case (q.dph_idx)
                IDX_RXC: d.rxc = hwdata[CW-1:0];
                IDX_TXC: d.txc = hwdata[CW-1:0];
                IDX_CLC: d.clc = hwdata[CW-1:0];
                serial_irq_pkg::IDX_SEL_A: d.sel_a = hwdata[7:0];
                serial_irq_pkg::IDX_SEL_B: d.sel_b = hwdata[7:0];
                serial_irq_pkg::IDX_MODE: begin
                    d.mode = hwdata[MW-1:0];
                    mode_chg = d.mode.smd != q.mode.smd ||
                               d.mode.twm != q.mode.twm ||
                               d.mode.sub != q.mode.sub ||
                               d.mode.cph != q.mode.cph;
                end
                serial_irq_pkg::IDX_XFER: d.xfer = hwdata[XW-1:0];
                serial_irq_pkg::IDX_TXB: begin
                    d.txbuf = hwdata[7:0];
                    d.tx_full = 1'b1;
                end
                serial_irq_pkg::IDX_STAT: d.stat = q.stat & ~hwdata[EW-1:0];
                serial_irq_pkg::IDX_MASK: d.mask = hwdata[EW-1:0];
                default: d.dph_wr = d.dph_wr;
            endcase
        end

        // completion source armed by select and error output: a rise
        // right after reset already requests, software then clears it
        d.tx_arm_prev = q.xfer.txirq_cmp && q.xfer.err_en &&
                        q.state == serial_irq_pkg::ST_IDLE;
        ev.tx = ev.tx || (d.tx_arm_prev && !q.tx_arm_prev);

        // hardware sets win over a clearing write in the same cycle
        mode_chg = mode_chg && d.mode.smd == serial_irq_pkg::MODE_TWO_WIRE;
        if (ev.rx || (ev.ovr && two_wire) ||
            mode_chg) begin
            d.rxc.ir = 1'b1;
        end
        if ((ev.tx && tx_route) || mode_chg) begin
            d.txc.ir = 1'b1;
        end
        if (ev.cond && coll_route) begin
            d.clc.ir = 1'b1;
        end
        d.stat = d.stat | ev;

        // ready-to-receive flag, dropped once a frame starts
        d.rts_n = !(q.mode.rts_en && !q.mode.int_clk && q.xfer.rx_en &&
                    d.state == serial_irq_pkg::ST_IDLE);
    end

    // single state register; reset takes constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.clk_prev <= 1'b1;
            q.clk_out <= 1'b1;
            q.dout <= 1'b1;
            q.rts_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // zero wait state slave; a read does not see a write of the transfer just before it
    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign serial_clock_pin_o = q.clk_out;
    assign serial_clock_pin_oe = q.mode.int_clk;
    assign serial_out_pin = q.dout;
    assign rts_n = q.rts_n;
    assign rx_vector_req = q.rxc.ir;
    assign tx_vector_req = q.txc.ir;
    assign coll_vector_req = q.clc.ir;
    assign irq = |(q.stat & q.mask);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_rx_rise_ir: assert property (
        $rose(q.rx_full) |-> q.rxc.ir)
        else $error("receive full rose without request");
    chk_ovr_quiet: assert property (
        ev.ovr && !two_wire && !q.rxc.ir && !wr_rxc && !mode_chg |=>
        !q.rxc.ir)
        else $error("overrun raised receive request");
    chk_ovr_two_wire: assert property (
        ev.ovr && two_wire |=> q.rxc.ir)
        else $error("two-wire overrun left request clear");
    chk_coll_route: assert property (
        ev.cond && !coll_route && !q.clc.ir && !wr_clc |=> !q.clc.ir)
        else $error("unrouted collision event requested");
    chk_rts_busy: assert property (
        q.state != serial_irq_pkg::ST_IDLE |-> q.rts_n)
        else $error("request-to-send low during frame");
    chk_rts_int_clk: assert property (
        q.mode.int_clk ##1 q.mode.int_clk |-> q.rts_n)
        else $error("request-to-send active on internal clock");
    chk_start_cond: assert property (
        q.state == serial_irq_pkg::ST_IDLE ##1
        q.state == serial_irq_pkg::ST_SHIFT |->
        $past(q.xfer.tx_en && q.tx_full && cts_ok))
        else $error("frame started without transmit conditions");
    chk_ovr_flag: assert property (
        ev.ovr |=> q.overrun && q.rx_full)
        else $error("overrun flag not set");
    chk_ir_sticky: assert property (
        q.rxc.ir && !wr_rxc |=> q.rxc.ir)
        else $error("receive request dropped without write");
    chk_frame_len: assert property (
        q.state == serial_irq_pkg::ST_SHIFT && q.mode.int_clk &&
        q.bitcnt == '0 |-> ##[1:600] q.state != serial_irq_pkg::ST_SHIFT)
        else $error("internal clock frame did not end");

    cov_overrun: cover property (ev.ovr);
    cov_rx_done: cover property (ev.rx && q.rx_act);
    cov_cond_gen: cover property (q.state == serial_irq_pkg::ST_COND);
    cov_tx_irq: cover property ($rose(q.txc.ir));
endmodule

// [shared/serial_irq_pkg.sv]
// constants, register map and types of the serial unit interrupt block
// Behaviour
// - receive-full rising from 0 to 1 sets the receive request flag
// - outside two-wire mode an overrun leaves the receive request alone
// - in two-wire mode an overrun also sets the receive request flag
// - channels 0 and 1 route collision events when their select bit is 1
// - channels 5 to 7 route collision and transmit events when select is 0
// - completion select plus error output enable after reset raises transmit
// - request-to-send goes low when ready to receive on external clock
// - request-to-send goes high as soon as a receive starts
// - request-to-send is inactive while the internal clock is selected
// - external clock start needs enable, full buffer, cts low, idle clock
// - edge select 0 shifts out falling, samples rising; 1 the reverse
// - shift clock only from an active transmitter, dummy data out on receive
// - internal clock shifting starts with transmit enabled and buffer written
// - new word while receive-full is set raises the overrun flag
// - external clock receive needs both enables, full buffer, idle clock
package serial_irq_pkg;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 12;
    localparam logic [11:0] IDX_SEL_B = 12'h205;
    localparam logic [11:0] IDX_SEL_A = 12'h206;
    localparam logic [11:0] IDX_MODE = 12'h300;
    localparam logic [11:0] IDX_XFER = 12'h301;
    localparam logic [11:0] IDX_TXB = 12'h302;
    localparam logic [11:0] IDX_RXB = 12'h303;
    localparam logic [11:0] IDX_STAT = 12'h304;
    localparam logic [11:0] IDX_MASK = 12'h305;
    localparam logic [2:0] MODE_TWO_WIRE = 3'h2;
    localparam logic [3:0] FRAME_LAST = 4'h7;
    localparam int RT_CH0_COLL = 6;
    localparam int RT_CH1_COLL = 7;
    localparam int RT_CH5_COLL = 3;
    localparam int RT_CH5_TX = 4;
    localparam int RT_CH6_COLL = 5;
    localparam int RT_CH6_TX = 6;
    localparam int RT_CH7_COLL = 4;
    localparam int RT_CH7_TX = 5;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1,
        ST_COND = 2'h3
    } state_type;

    typedef struct packed {
        logic cph;
        logic sub;
        logic twm;
        logic cts_en;
        logic rts_en;
        logic int_clk;
        logic [2:0] smd;
    } mode_type;

    typedef struct packed {
        logic stp_req;
        logic rst_req;
        logic sta_req;
        logic cond_sel;
        logic err_en;
        logic txirq_cmp;
        logic edge_sel;
        logic rx_en;
        logic tx_en;
    } xfer_type;

    typedef struct packed {
        logic ir;
        logic [2:0] lvl;
    } irqctl_type;

    typedef struct packed {
        logic cond;
        logic ovr;
        logic tx;
        logic rx;
    } evt_type;

    function automatic logic channel_ok(input int ch);
        return ch inside {0, 1, 2, 5, 6, 7};
    endfunction

    // register index of the receive, transmit and collision controls
    function automatic logic [11:0] ctl_idx(input int ch, input int kind);
        logic [11:0] t [3];
        t = '{12'h0, 12'h0, 12'h0};
        case (ch)
            0: t = '{12'h52, 12'h51, 12'h47};
            1: t = '{12'h54, 12'h53, 12'h46};
            2: t = '{12'h50, 12'h4f, 12'h4a};
            5: t = '{12'h6d, 12'h6c, 12'h6b};
            6: t = '{12'h70, 12'h6f, 12'h6e};
            7: t = '{12'h73, 12'h72, 12'h71};
            default: t = '{12'h0, 12'h0, 12'h0};
        endcase
        return t[kind];
    endfunction

    // shared-vector routing of collision (tx=0) or transmit (tx=1) events
    function automatic logic route_ok(input int ch, input logic tx,
                                      input logic [7:0] a,
                                      input logic [7:0] b);
        case (ch)
            0: return tx | a[RT_CH0_COLL];
            1: return tx | a[RT_CH1_COLL];
            5: return tx ? ~b[RT_CH5_TX] : ~b[RT_CH5_COLL];
            6: return tx ? ~b[RT_CH6_TX] : ~b[RT_CH6_COLL];
            7: return tx ? ~a[RT_CH7_TX] : ~a[RT_CH7_COLL];
            default: return 1'b1;
        endcase
    endfunction
endpackage
